// [hdl/bcs_pkg.sv]
// Purpose: constants for the branch, compare and skip unit
// Assumes: 16-bit instruction words, 16-bit word-addressed PC
// Notes: the conditional branches share one decode path
package bcs_pkg;
	localparam int PC_W = 16;
	// Flag register bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// Opcode patterns and masks
	localparam logic [15:0] MASK_6   = 16'hFC00;
	localparam logic [15:0] OP_EQ_SKIP      = 16'h1000;
	localparam logic [15:0] OP_CMP_REG      = 16'h1400;
	localparam logic [15:0] OP_CMP_BORROW   = 16'h0400;
	localparam logic [15:0] MASK_4   = 16'hF000;
	localparam logic [15:0] OP_CMP_IMM      = 16'h3000;
	localparam logic [15:0] MASK_REG_BIT    = 16'hFE08;
	localparam logic [15:0] OP_REG_BIT_LOW  = 16'hFC00;
	localparam logic [15:0] OP_REG_BIT_HIGH = 16'hFE00;
	localparam logic [15:0] MASK_8   = 16'hFF00;
	localparam logic [15:0] OP_IO_BIT_LOW   = 16'h9900;
	localparam logic [15:0] OP_IO_BIT_HIGH  = 16'h9B00;
	localparam logic [15:0] MASK_BR  = 16'hFC00;
	localparam logic [15:0] OP_FLAG_SET     = 16'hF000;
	localparam logic [15:0] OP_FLAG_CLEAR   = 16'hF400;
	localparam logic [15:0] MASK_CALL = 16'hFE0E;
	localparam logic [15:0] OP_CALL  = 16'h940E;
	localparam logic [15:0] MASK_JMP = 16'hFE0C;
	localparam logic [15:0] OP_JMP   = 16'h940C;
	localparam logic [15:0] OP_LDS   = 16'h9000;
	localparam logic [15:0] OP_STS   = 16'h9200;
	localparam logic [15:0] MASK_LDS = 16'hFE0F;
	localparam logic [15:0] OP_ROUTINE_EXIT = 16'h9508;
	localparam logic [15:0] OP_IRQ_EXIT     = 16'h9518;
	// Cycle counts
	localparam logic [1:0] CYC_SKIP1   = 2'h1;
	localparam logic [1:0] CYC_SKIP2   = 2'h2;
	localparam logic [1:0] CYC_BRANCH  = 2'h1;
	localparam logic [1:0] CYC_FOUR    = 2'h3;
	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
endpackage : bcs_pkg

// [hdl/flag_compare.sv]
// Purpose: subtract-and-flag unit for the compare instructions
// Assumes: operands and carry-in presented combinationally
// Notes: produces flags only, no result is stored
`timescale 1ns/1ns
`default_nettype none
module flag_compare (
	// Operands
	input  wire logic [7:0] lhs,
	input  wire logic [7:0] rhs,
	input  wire logic       borrow_in,
	input  wire logic       chain_z,
	input  wire logic       use_chain,
	// Flags
	output logic            flag_z,
	output logic            flag_n,
	output logic            flag_v,
	output logic            flag_c,
	output logic            flag_h,
	output logic            flag_s
);
	logic [7:0] diff;
	logic [8:0] wide;

	always_comb begin
		wide   = {1'b0, lhs} - {1'b0, rhs} - {8'h00, borrow_in};
		diff   = wide[7:0];
		flag_c = (~lhs[7] & rhs[7]) | (rhs[7] & diff[7]) | (diff[7] & ~lhs[7]);
		flag_h = (~lhs[3] & rhs[3]) | (rhs[3] & diff[3]) | (diff[3] & ~lhs[3]);
		flag_v = (lhs[7] & ~rhs[7] & ~diff[7]) | (~lhs[7] & rhs[7] & diff[7]);
		flag_n = diff[7];
		flag_s = flag_n ^ flag_v;
		// Borrow form keeps Z only if it was already set
		flag_z = (diff == 8'h00) & (~use_chain | chain_z);
	end
endmodule : flag_compare
`default_nettype wire

// [hdl/branch_compare_skip_unit.sv]
// Purpose: control flow for compare, skip, branch, call and return
// Assumes: instruction, operands and I/O bit valid with INSTR_VALID
// Notes: stack access itself lives outside; this unit sequences it
`timescale 1ns/1ns
`default_nettype none
module branch_compare_skip_unit (
	// Clock and reset
	input  wire logic                   CORE_CLK,
	input  wire logic                   NRST,
	input  wire logic                   CLK_EN,
	// Instruction stream
	input  wire logic                   INSTR_VALID,
	input  wire logic [15:0]            INSTR,
	input  wire logic [15:0]            NEXT_INSTR,
	input  wire logic [15:0]            EXT_WORD,
	// Register file and I/O read paths
	input  wire logic [7:0]             RD_DATA,
	input  wire logic [7:0]             RR_DATA,
	input  wire logic                   IO_BIT,
	// Stack
	input  wire logic [bcs_pkg::PC_W-1:0] STACK_PC,
	// Program counter and flags
	output logic [bcs_pkg::PC_W-1:0]    PC,
	output logic [7:0]                  FLAGS,
	output logic                        BUSY,
	output logic                        STACK_PUSH,
	output logic                        STACK_POP,
	output logic [bcs_pkg::PC_W-1:0]    RETURN_ADDR
);
	import bcs_pkg::*;

	typedef enum {ST_RUN, ST_WAIT} state_e;

	// Sequencer state
	state_e          state;
	logic [1:0]      wait_cnt;
	logic [PC_W-1:0] pending_pc;

	// Instruction decode
	logic            is_eq_skip;
	logic            is_cmp_reg;
	logic            is_cmp_borrow;
	logic            is_cmp_imm;
	logic            is_reg_low;
	logic            is_reg_high;
	logic            is_io_low;
	logic            is_io_high;
	logic            is_flag_set;
	logic            is_flag_clear;
	logic            is_call;
	logic            is_exit;
	logic            is_irq_exit;
	logic            is_compare;
	logic            next_two_word;

	// Conditions and operands
	logic            skip_cond;
	logic            br_cond;
	logic            sel_flag;
	logic [7:0]      cmp_rhs;
	logic            cmp_borrow;
	logic [PC_W-1:0] br_offset;
	logic [PC_W-1:0] skip_step;

	// Compare unit results
	logic            cz;
	logic            cn;
	logic            cv;
	logic            cc;
	logic            ch;
	logic            cs;

	// Flag register bits
	logic            flag_c;
	logic            flag_z;
	logic            flag_n;
	logic            flag_v;
	logic            flag_s;
	logic            flag_h;
	logic            flag_i;

	// Issue qualifiers
	logic            issue;
	logic            wait_done;
	logic            start_skip;
	logic            start_branch;
	logic            start_call;
	logic            start_exit;
	logic            start_wait;

	// Next values
	logic [1:0]      next_wait_cnt;
	logic [PC_W-1:0] next_pending_pc;

	assign issue     = CLK_EN & INSTR_VALID & (state == ST_RUN);
	assign wait_done = CLK_EN & (state == ST_WAIT) & (wait_cnt == 2'h1);
	assign BUSY      = state == ST_WAIT;

	always_comb begin
		is_eq_skip    = (INSTR & MASK_6) == OP_EQ_SKIP;
		is_cmp_reg    = (INSTR & MASK_6) == OP_CMP_REG;
		is_cmp_borrow = (INSTR & MASK_6) == OP_CMP_BORROW;
		is_cmp_imm    = (INSTR & MASK_4) == OP_CMP_IMM;
		is_reg_low    = (INSTR & MASK_REG_BIT) == OP_REG_BIT_LOW;
		is_reg_high   = (INSTR & MASK_REG_BIT) == OP_REG_BIT_HIGH;
		is_io_low     = (INSTR & MASK_8) == OP_IO_BIT_LOW;
		is_io_high    = (INSTR & MASK_8) == OP_IO_BIT_HIGH;
		is_flag_set   = (INSTR & MASK_BR) == OP_FLAG_SET;
		is_flag_clear = (INSTR & MASK_BR) == OP_FLAG_CLEAR;
		is_call       = (INSTR & MASK_CALL) == OP_CALL;
		is_exit       = INSTR == OP_ROUTINE_EXIT;
		is_irq_exit   = INSTR == OP_IRQ_EXIT;
		is_compare    = is_cmp_reg | is_cmp_borrow | is_cmp_imm;
	end

	// Skipped instruction length decides 2 or 3 cycle skip
	always_comb begin
		next_two_word = ((NEXT_INSTR & MASK_JMP) == OP_JMP)
			| ((NEXT_INSTR & MASK_LDS) == OP_LDS)
			| ((NEXT_INSTR & MASK_LDS) == OP_STS);
	end

	// Immediate form: K split across the opcode
	assign cmp_rhs    = is_cmp_imm ? {INSTR[11:8], INSTR[3:0]} : RR_DATA;
	assign cmp_borrow = is_cmp_borrow & flag_c;

	flag_compare u_cmp (
		.lhs       (RD_DATA),
		.rhs       (cmp_rhs),
		.borrow_in (cmp_borrow),
		.chain_z   (flag_z),
		.use_chain (is_cmp_borrow),
		.flag_z    (cz),
		.flag_n    (cn),
		.flag_v    (cv),
		.flag_c    (cc),
		.flag_h    (ch),
		.flag_s    (cs)
	);

	always_comb begin
		skip_cond = 1'b0;
		if (is_eq_skip)
			skip_cond = RD_DATA == RR_DATA;
		else if (is_reg_low)
			skip_cond = ~RR_DATA[INSTR[2:0]];
		else if (is_reg_high)
			skip_cond = RR_DATA[INSTR[2:0]];
		else if (is_io_low)
			skip_cond = ~IO_BIT;
		else if (is_io_high)
			skip_cond = IO_BIT;
	end

	// Aliases (equal, carry, unsigned, signed, half, T) are flag selects
	always_comb begin
		sel_flag = FLAGS[INSTR[2:0]];
		// S flag holds N^V, so signed branches use bit 4
		br_cond = is_flag_set ? sel_flag : ~sel_flag;
		br_cond = br_cond & (is_flag_set | is_flag_clear);
	end

	// Signed 7-bit displacement, sign extended
	assign br_offset = {{(PC_W-7){INSTR[9]}}, INSTR[9:3]};
	assign skip_step = next_two_word ? 16'h0003 : 16'h0002;

	// Decode is exclusive; the priority only guards against odd words
	always_comb begin
		start_skip   = issue & skip_cond;
		start_branch = issue & ~skip_cond & br_cond;
		start_call   = issue & ~skip_cond & ~br_cond & is_call;
		start_exit   = issue & ~skip_cond & ~br_cond & ~is_call
			& (is_exit | is_irq_exit);
		start_wait   = start_skip | start_branch | start_call | start_exit;
	end

	// Extra wait cycles stand for fetch of the skipped or target words
	always_comb begin
		next_pending_pc = pending_pc;
		next_wait_cnt   = wait_cnt;
		if (start_skip) begin
			next_pending_pc = PC + skip_step;
			next_wait_cnt   = next_two_word ? CYC_SKIP2 : CYC_SKIP1;
		end else if (start_branch) begin
			next_pending_pc = PC + br_offset + 16'h0001;
			next_wait_cnt   = CYC_BRANCH;
		end else if (start_call) begin
			next_pending_pc = EXT_WORD;
			next_wait_cnt   = CYC_FOUR;
		end else if (start_exit) begin
			next_pending_pc = STACK_PC;
			next_wait_cnt   = CYC_FOUR;
		end else if (state == ST_WAIT) begin
			next_wait_cnt   = wait_cnt - 2'h1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			state <= ST_RUN;
		end else if (CLK_EN) begin
			unique case (state)
				ST_RUN: begin
					if (start_wait)
						state <= ST_WAIT;
				end
				ST_WAIT: begin
					if (wait_cnt == 2'h1)
						state <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			wait_cnt <= 2'h0;
		end else if (CLK_EN) begin
			wait_cnt <= next_wait_cnt;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			pending_pc <= PC_RESET;
		end else if (CLK_EN) begin
			pending_pc <= next_pending_pc;
		end
	end

	// PC moves only by whole instructions
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			PC <= PC_RESET;
		end else if (wait_done) begin
			PC <= pending_pc;
		end else if (issue & ~start_wait) begin
			PC <= PC + 16'h0001;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			STACK_PUSH <= 1'b0;
		end else if (CLK_EN) begin
			STACK_PUSH <= start_call;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			STACK_POP <= 1'b0;
		end else if (CLK_EN) begin
			STACK_POP <= start_exit;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			RETURN_ADDR <= PC_RESET;
		end else if (start_call) begin
			RETURN_ADDR <= PC + 16'h0002;
		end
	end

	// Borrow form chains Z inside the compare unit
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			flag_z <= 1'b0;
		end else if (issue & is_compare) begin
			flag_z <= cz;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			flag_n <= 1'b0;
			flag_v <= 1'b0;
			flag_s <= 1'b0;
		end else if (issue & is_compare) begin
			flag_n <= cn;
			flag_v <= cv;
			flag_s <= cs;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			flag_c <= 1'b0;
			flag_h <= 1'b0;
		end else if (issue & is_compare) begin
			flag_c <= cc;
			flag_h <= ch;
		end
	end

	// Only the interrupt return touches I here
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			flag_i <= 1'b0;
		end else if (issue & is_irq_exit) begin
			flag_i <= 1'b1;
		end
	end

	// T is never written by this unit, so it reads as zero
	always_comb begin
		FLAGS         = 8'h00;
		FLAGS[FLAG_C] = flag_c;
		FLAGS[FLAG_Z] = flag_z;
		FLAGS[FLAG_N] = flag_n;
		FLAGS[FLAG_V] = flag_v;
		FLAGS[FLAG_S] = flag_s;
		FLAGS[FLAG_H] = flag_h;
		FLAGS[FLAG_I] = flag_i;
	end
endmodule : branch_compare_skip_unit
`default_nettype wire

// [verif/bcs_asserts.sv]
// Purpose: port checker for the branch, compare and skip unit
// Assumes: PC counts words
// Notes: bound to the top module
`timescale 1ns/1ns
`default_nettype none
module bcs_checker (
	// Watched ports
	input wire logic                     CORE_CLK,
	input wire logic                     NRST,
	input wire logic                     CLK_EN,
	input wire logic                     INSTR_VALID,
	input wire logic [15:0]              INSTR,
	input wire logic [15:0]              NEXT_INSTR,
	input wire logic [7:0]               RD_DATA,
	input wire logic [7:0]               RR_DATA,
	input wire logic                     IO_BIT,
	input wire logic [bcs_pkg::PC_W-1:0] STACK_PC,
	input wire logic [bcs_pkg::PC_W-1:0] PC,
	input wire logic [7:0]               FLAGS,
	input wire logic                     BUSY
);
	import bcs_pkg::*;
	logic [15:0] tgt;
	wire go = CLK_EN && INSTR_VALID && !BUSY;
	wire cmp_go = go && (INSTR & MASK_6) == OP_CMP_REG;
	wire br = go && (INSTR & 16'hF800) == OP_FLAG_SET;
	wire hit = FLAGS[INSTR[2:0]] ^ INSTR[10];
	wire io = go && (INSTR & 16'hFD00) == OP_IO_BIT_LOW;
	// Jump, call, load and store direct are the two-word followers
	wire two = ((NEXT_INSTR & MASK_JMP) == OP_JMP)
		|| ((NEXT_INSTR & MASK_LDS) == OP_LDS)
		|| ((NEXT_INSTR & MASK_LDS) == OP_STS);
	// Target frozen at issue; nothing issues while busy
	always_ff @(posedge CORE_CLK) begin
		if (go)
			tgt <= PC + {{9{INSTR[9]}}, INSTR[9:3]} + 16'h0001;
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	a_cmp_zero: assert property (
		cmp_go |=> FLAGS[FLAG_Z] == ($past(RD_DATA) == $past(RR_DATA)))
		else $error("compare zero flag wrong");
	a_cmp_carry: assert property (
		cmp_go |=> FLAGS[FLAG_C] == ($past(RD_DATA) < $past(RR_DATA)))
		else $error("compare carry flag wrong");
	a_equal_skip: assert property (
		go && (INSTR & MASK_6) == OP_EQ_SKIP && RD_DATA == RR_DATA && !two
		|=> BUSY ##1 (!BUSY && PC == $past(PC, 2) + 16'h0002))
		else $error("equal skip wrong");
	a_io_skip: assert property (
		io && IO_BIT == INSTR[9] && two
		|=> BUSY [*2] ##1 (!BUSY && PC == $past(PC, 3) + 16'h0003))
		else $error("io skip wrong");
	a_io_stay: assert property (
		io && IO_BIT != INSTR[9] |=> !BUSY && PC == $past(PC) + 16'h0001)
		else $error("io no skip wrong");
	a_branch_taken: assert property (
		br && hit |=> BUSY ##1 (!BUSY && PC == tgt))
		else $error("taken branch wrong");
	a_branch_idle: assert property (
		br && !hit |=> !BUSY && PC == $past(PC) + 16'h0001)
		else $error("idle branch wrong");
	a_return_len: assert property (
		go && INSTR == OP_ROUTINE_EXIT
		|=> BUSY [*3] ##1 (!BUSY && PC == $past(STACK_PC, 4)))
		else $error("return timing wrong");
endmodule : bcs_checker
bind branch_compare_skip_unit bcs_checker bcs_checker_inst (.CORE_CLK, .NRST,
	.CLK_EN, .INSTR_VALID, .INSTR, .NEXT_INSTR, .RD_DATA, .RR_DATA, .IO_BIT,
	.STACK_PC, .PC, .FLAGS, .BUSY);
`default_nettype wire

// [verif/tb_branch_compare_skip_unit.sv]
// Purpose: directed bench for the branch, compare and skip unit
// Assumes: CLK_EN high outside the freeze check; operands held
// Notes: offsets are words from the PC before issue
`timescale 1ns/1ns
`default_nettype none
module tb_branch_compare_skip_unit;
	import bcs_pkg::*;
	logic        CORE_CLK = 1'b0;
	logic        NRST = 1'b0;
	logic        CLK_EN = 1'b1;
	logic        INSTR_VALID = 1'b0;
	logic [15:0] EXT_WORD = 16'h0000;
	logic        IO_BIT = 1'b0;
	logic [15:0] INSTR = 16'h0000;
	logic [15:0] NEXT_INSTR = 16'h0000;
	logic [15:0] STACK_PC = 16'h0000;
	logic [7:0]  RD_DATA = 8'h00;
	logic [7:0]  RR_DATA = 8'h00;
	wire logic [15:0] PC;
	wire logic [7:0]  FLAGS;
	wire logic        BUSY;
	wire logic        STACK_PUSH;
	wire logic        STACK_POP;
	wire logic [15:0] RETURN_ADDR;
	int n_fail = 0;
	int checked = 0;
	branch_compare_skip_unit branch_compare_skip_unit_inst (.CORE_CLK, .NRST,
		.CLK_EN, .INSTR_VALID, .INSTR, .NEXT_INSTR, .EXT_WORD,
		.RD_DATA, .RR_DATA, .IO_BIT, .STACK_PC, .PC, .FLAGS, .BUSY,
		.STACK_PUSH, .STACK_POP, .RETURN_ADDR);
	initial begin
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	task automatic chk(input string nm, input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Busy is counted in whole cycles after the issue edge
	task automatic run(input logic [15:0] i, off, input int eb);
		logic [15:0] p;
		int b;
		@(negedge CORE_CLK);
		p = PC;
		INSTR = i;
		INSTR_VALID = 1'b1;
		@(negedge CORE_CLK);
		INSTR_VALID = 1'b0;
		b = 0;
		while (BUSY === 1'b1 && b < 8) begin
			b++;
			@(negedge CORE_CLK);
		end
		chk("pc", p + off, PC);
		chk("busy cycles", 16'(eb), 16'(b));
	endtask : run
	task automatic cmp(input logic [15:0] op, input logic [7:0] d, r, f);
		RD_DATA = d;
		RR_DATA = r;
		run(op, 16'h0001, 0);
		chk("flags", {8'h00, f}, {8'h00, FLAGS});
	endtask : cmp
	task automatic t_skip();
		logic [15:0] ops [4] = '{OP_REG_BIT_LOW, OP_REG_BIT_HIGH,
			OP_IO_BIT_LOW, OP_IO_BIT_HIGH};
		logic sk;
		RD_DATA = 8'h5A;
		RR_DATA = 8'h5A;
		NEXT_INSTR = OP_LDS;
		run(OP_EQ_SKIP, 16'h0003, 2);
		NEXT_INSTR = 16'h0000;
		run(OP_EQ_SKIP, 16'h0002, 1);
		RR_DATA = 8'h5B;
		run(OP_EQ_SKIP, 16'h0001, 0);
		foreach (ops[j]) begin
			for (int v = 0; v < 2; v++) begin
				IO_BIT = v[0];
				RR_DATA = v[0] ? 8'h20 : 8'hDF;
				NEXT_INSTR = v[0] ? OP_CALL : 16'h0000;
				sk = (v[0] == ops[j][9]);
				run(ops[j] | 16'h0005, sk ? 16'h0002 + 16'(v) : 16'h0001,
					sk ? 1 + v : 0);
			end
		end
		$display("test skip done");
	endtask : t_skip
	task automatic t_return();
		STACK_PC = 16'h0123;
		run(OP_ROUTINE_EXIT, 16'h0123 - PC, 3);
		run(OP_IRQ_EXIT, 16'h0000, 3);
		chk("flag i", 16'h0001, {15'h0000, FLAGS[7]});
		$display("test return done");
	endtask : t_return
	// Call pushes PC+2, exit pops; nothing moves while enable is low
	task automatic t_call();
		logic [15:0] p;
		@(negedge CORE_CLK);
		p = PC;
		CLK_EN = 1'b0;
		INSTR = OP_CALL;
		EXT_WORD = 16'h0456;
		INSTR_VALID = 1'b1;
		@(negedge CORE_CLK);
		chk("frozen pc", p, PC);
		chk("frozen busy", 16'h0000, {15'h0000, BUSY});
		CLK_EN = 1'b1;
		@(negedge CORE_CLK);
		INSTR_VALID = 1'b0;
		chk("push", 16'h0001, {15'h0000, STACK_PUSH});
		chk("return addr", p + 16'h0002, RETURN_ADDR);
		repeat (3) @(negedge CORE_CLK);
		chk("call pc", 16'h0456, PC);
		chk("push end", 16'h0000, {15'h0000, STACK_PUSH});
		STACK_PC = 16'h0200;
		INSTR = OP_ROUTINE_EXIT;
		INSTR_VALID = 1'b1;
		@(negedge CORE_CLK);
		INSTR_VALID = 1'b0;
		chk("pop", 16'h0001, {15'h0000, STACK_POP});
		repeat (3) @(negedge CORE_CLK);
		chk("exit pc", 16'h0200, PC);
		$display("test call done");
	endtask : t_call
	// Reset in mid-run, then an instruction at the second edge after
	task automatic t_reset();
		@(negedge CORE_CLK);
		NRST = 1'b0;
		@(negedge CORE_CLK);
		chk("reset pc", PC_RESET, PC);
		chk("reset flags", 16'h0000, {8'h00, FLAGS});
		NRST = 1'b1;
		cmp(OP_CMP_IMM | 16'h0100, 8'h10, 8'h00, 8'h02);
		$display("test reset done");
	endtask : t_reset
	// Flag-clear forms jump back by one to exercise a negative offset
	task automatic t_branch(input logic [7:0] d, r, f);
		logic t;
		logic [15:0] i;
		logic [15:0] o;
		cmp(OP_CMP_REG, d, r, f);
		for (int s = 0; s < 16; s++) begin
			t = f[s[2:0]] ^ s[3];
			i = s[3] ? OP_FLAG_CLEAR | 16'h03F0 : OP_FLAG_SET | 16'h0018;
			o = s[3] ? 16'hFFFF : 16'h0004;
			run(i | 16'(s[2:0]), t ? o : 16'h0001, t ? 1 : 0);
		end
		$display("test branch done");
	endtask : t_branch
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial begin
		#100000;
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (6) @(negedge CORE_CLK);
		NRST = 1'b1;
		t_skip();
		t_return();
		t_call();
		t_branch(8'h05, 8'h05, 8'h82);
		t_branch(8'h03, 8'h05, 8'hB5);
		cmp(OP_CMP_BORROW, 8'h06, 8'h05, 8'h80);
		t_branch(8'h80, 8'h01, 8'hB8);
		cmp(OP_CMP_IMM | 16'h0100, 8'h10, 8'h00, 8'h82);
		t_reset();
		give_verdict();
	end
endmodule : tb_branch_compare_skip_unit
`default_nettype wire
